// ### hdl/rxs_pkg.sv
// Purpose: shared constants and carriers for the receive status block
// Assumes: one receive clock, all event inputs synchronous to it
// Notes: widths fixed at the documented values
package rxs_pkg;
  localparam int PCS_LANE_COUNT = 20;            // pcs lanes in the metaframe
  localparam int LANE_IDX_W = 5;                 // width of a pcs lane number
  localparam int CNT_W = 2;                      // width of fcs count pulses
  localparam int LEN_W = 15;                     // max packet length setting width
  localparam int PRE_W = 56;                     // preamble bytes width
  localparam int MF_LEN_W = 14;                  // metaframe word counter width
  localparam logic [MF_LEN_W-1:0] MF_LEN_RST = 14'h3FFF; // default metaframe words minus one
  localparam logic [1:0] LF_TRIG = 2'h3;         // lf words (minus one) to enter fault
  localparam logic [6:0] LF_CLEAR = 7'h7F;       // good columns (minus one) to leave fault
  localparam logic [LEN_W-1:0] LEN_RST = 15'h0000; // reset value of byte counter

  // states of the received local fault tracker
  typedef enum logic [2:0] {
    RXS_LF_OK    = 3'b001,
    RXS_LF_COUNT = 3'b010,
    RXS_LF_FAULT = 3'b100
  } rxs_lf_state_t;

  // per-beat receive packet events
  typedef struct packed {
    logic sop;                   // first beat of a packet
    logic eop;                   // last beat of a packet
    logic fcs_ok;                // fcs matched at eop
    logic fcs_inverted;          // fcs equals inverse of expected
    logic [7:0] bytes;           // bytes in this beat
  } rxs_pkt_t;
endpackage

// ### hdl/rxs_status.sv
// Purpose: receive path status and error indication
// Assumes: lane events arrive from the lane aligner in the clock domain
// Notes: pulses are one cycle wide and may repeat every cycle
`timescale 1ns/100ps
module rxs_status (
  input wire logic clock,                                           // receive clock, 25 mhz
  input wire logic rst_b,                                           // async reset, active low
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] lane_marker_ok,    // good marker seen per lane
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] lane_marker_bad,   // wrong marker seen per lane
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] lane_marker_malformed, // malformed marker word per lane
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] lane_bip_bad,      // bip8 mismatch per lane
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] lane_synced,       // word sync per physical lane
  input wire logic [rxs_pkg::PCS_LANE_COUNT*rxs_pkg::LANE_IDX_W-1:0] lane_id_in, // decoded lane ids
  input wire logic align_fail,                                      // aligner could not deskew
  input wire logic remote_fault_seen,                               // remote fault ordered set seen
  input wire logic lf_word_seen,                                    // local fault word this column
  input wire logic process_lfi,                                     // honour received lf words
  input wire logic test_pattern_gen,                                // test pattern generation on
  input wire logic ber_over,                                        // ber monitor over threshold
  input wire rxs_pkg::rxs_pkt_t pkt,                                // packet beat events
  input wire logic pkt_valid,                                       // pkt fields valid this beat
  input wire logic [rxs_pkg::LEN_W-1:0] max_packet_len,             // longest allowed packet
  input wire logic custom_preamble_enable,                          // present preamble bytes
  input wire logic [rxs_pkg::PRE_W-1:0] preamble_in,                // preamble bytes of packet
  output logic aligned_err,                                         // alignment error level
  output logic misaligned_pulse,                                    // metaframe late misalign
  output logic remote_fault,                                        // remote fault level
  output logic [rxs_pkg::PCS_LANE_COUNT*rxs_pkg::LANE_IDX_W-1:0] phys_lane_pcs_index, // lane numbers
  output logic [rxs_pkg::PCS_LANE_COUNT-1:0] pcs_lane_demux_done,   // lane demuxed levels
  output logic [rxs_pkg::CNT_W-1:0] bad_fcs_count,                  // bad fcs count pulse
  output logic [rxs_pkg::CNT_W-1:0] stomped_fcs_count,              // stomped fcs count pulse
  output logic truncated_pulse,                                     // truncation pulse
  output logic truncate_now,                                        // drop rest of packet
  output logic internal_local_fault,                                // internal lf level
  output logic received_local_fault,                                // received lf level
  output logic local_fault,                                         // combined lf level
  output logic [rxs_pkg::PCS_LANE_COUNT-1:0] bip_err_pulse,         // bip8 error pulses
  output logic high_error_rate_level,                               // high ber level
  output logic [rxs_pkg::PCS_LANE_COUNT-1:0] marker_word_err_pulse, // marker word error pulses
  output logic [rxs_pkg::PRE_W-1:0] preamble_out                    // received preamble
);

  // ---------------------------------------------------------------
  // state declarations
  // ---------------------------------------------------------------
  logic [rxs_pkg::PCS_LANE_COUNT-1:0] seen_ok;        // lanes with a good marker seen
  logic [rxs_pkg::PCS_LANE_COUNT-1:0] next_seen_ok;
  logic armed;                                        // all lanes once correct
  logic next_armed;
  logic err_pending;                                  // marker error awaiting metaframe end
  logic next_err_pending;
  logic [rxs_pkg::MF_LEN_W-1:0] mf_cnt;               // metaframe word counter
  logic [rxs_pkg::MF_LEN_W-1:0] next_mf_cnt;
  logic next_misaligned_pulse;
  logic next_aligned_err;
  logic next_remote_fault;
  logic [rxs_pkg::PCS_LANE_COUNT*rxs_pkg::LANE_IDX_W-1:0] next_index;
  logic [rxs_pkg::PCS_LANE_COUNT-1:0] next_demux;
  logic [rxs_pkg::PCS_LANE_COUNT-1:0] next_bip;
  logic [rxs_pkg::PCS_LANE_COUNT-1:0] next_mfe;
  logic [rxs_pkg::CNT_W-1:0] next_bad;
  logic [rxs_pkg::CNT_W-1:0] next_stomp;
  logic [rxs_pkg::LEN_W-1:0] byte_cnt;                // bytes so far in packet
  logic [rxs_pkg::LEN_W-1:0] next_byte_cnt;
  logic in_trunc;                                     // current packet already truncated
  logic next_in_trunc;
  logic next_truncated;
  logic next_internal_lf;
  logic next_high_ber;
  rxs_pkg::rxs_lf_state_t lf_state;                   // received lf tracker state
  rxs_pkg::rxs_lf_state_t next_lf_state;
  logic [1:0] lf_cnt;                                 // lf words counted
  logic [1:0] next_lf_cnt;
  logic [6:0] good_cnt;                               // clean columns while in fault
  logic [6:0] next_good_cnt;
  logic next_received_lf;
  logic [rxs_pkg::PRE_W-1:0] next_preamble;
  logic [rxs_pkg::LEN_W:0] sum_len;                   // byte count plus this beat

  // ---------------------------------------------------------------
  // per lane status
  // ---------------------------------------------------------------
  // per lane pulses, demux flags and lane numbers
  genvar g;
  generate
    for (g = 0; g < rxs_pkg::PCS_LANE_COUNT; g++) begin : g_lane
      always_comb begin
        next_bip[g] = lane_bip_bad[g];
        next_mfe[g] = lane_marker_malformed[g];
        next_demux[g] = lane_synced[g] & (seen_ok[g] | lane_marker_ok[g]);
        next_seen_ok[g] = lane_synced[g] & (seen_ok[g] | lane_marker_ok[g]);
        // number only meaningful while the lane is synced
        next_index[g*rxs_pkg::LANE_IDX_W +: rxs_pkg::LANE_IDX_W] =
          lane_synced[g] ? lane_id_in[g*rxs_pkg::LANE_IDX_W +: rxs_pkg::LANE_IDX_W]
                         : phys_lane_pcs_index[g*rxs_pkg::LANE_IDX_W +: rxs_pkg::LANE_IDX_W];
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // alignment and misalignment
  // ---------------------------------------------------------------
  // misalign reported at the metaframe boundary after the bad marker
  always_comb begin
    next_armed = armed | (&next_seen_ok);
    next_mf_cnt = (mf_cnt == '0) ? rxs_pkg::MF_LEN_RST : mf_cnt - 1'b1;
    next_err_pending = err_pending;
    next_misaligned_pulse = 1'b0;
    if (armed && (|lane_marker_bad)) begin
      next_err_pending = 1'b1;
    end
    if (mf_cnt == '0) begin
      next_misaligned_pulse = err_pending;
      next_err_pending = armed & (|lane_marker_bad);
    end
    if (|lane_marker_ok) begin
      next_mf_cnt = rxs_pkg::MF_LEN_RST;                         // realign counter on marker
    end
    next_aligned_err = align_fail | (armed & ~(&lane_synced));
    next_remote_fault = remote_fault_seen;
  end

  // ---------------------------------------------------------------
  // packet checks
  // ---------------------------------------------------------------
  // fcs classification, length tracking and preamble capture
  always_comb begin
    next_bad = '0;
    next_stomp = '0;
    next_truncated = 1'b0;
    next_byte_cnt = byte_cnt;
    next_in_trunc = in_trunc;
    next_preamble = preamble_out;
    sum_len = {1'b0, byte_cnt} + {{(rxs_pkg::LEN_W-8+1){1'b0}}, pkt.bytes};
    truncate_now = 1'b0;
    if (pkt_valid) begin
      if (pkt.sop) begin
        sum_len = {{(rxs_pkg::LEN_W-8+1){1'b0}}, pkt.bytes};
        next_in_trunc = 1'b0;
        if (custom_preamble_enable) begin
          next_preamble = preamble_in;
        end
      end
      if ((sum_len > {1'b0, max_packet_len}) && !(in_trunc && !pkt.sop)) begin
        truncate_now = 1'b1;
        next_truncated = 1'b1;
        next_in_trunc = 1'b1;
      end
      next_byte_cnt = sum_len[rxs_pkg::LEN_W] ? {rxs_pkg::LEN_W{1'b1}} : sum_len[rxs_pkg::LEN_W-1:0];
      if (pkt.eop) begin
        next_byte_cnt = rxs_pkg::LEN_RST;
        if (pkt.fcs_inverted) begin
          next_stomp = {{(rxs_pkg::CNT_W-1){1'b0}}, 1'b1};
        end else if (!pkt.fcs_ok) begin
          next_bad = {{(rxs_pkg::CNT_W-1){1'b0}}, 1'b1};
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // fault tracking
  // ---------------------------------------------------------------
  // received lf: enter after several lf words, leave after clean run
  always_comb begin
    next_lf_state = lf_state;
    next_lf_cnt = lf_cnt;
    next_good_cnt = good_cnt;
    case (lf_state)
      rxs_pkg::RXS_LF_OK: begin
        next_lf_cnt = '0;
        if (process_lfi && lf_word_seen) begin
          next_lf_state = rxs_pkg::RXS_LF_COUNT;
        end
      end
      rxs_pkg::RXS_LF_COUNT: begin
        if (!(process_lfi && lf_word_seen)) begin
          next_lf_state = rxs_pkg::RXS_LF_OK;
        end else if (lf_cnt == rxs_pkg::LF_TRIG - 2'h1) begin
          next_lf_state = rxs_pkg::RXS_LF_FAULT;
          next_good_cnt = '0;
        end else begin
          next_lf_cnt = lf_cnt + 2'h1;
        end
      end
      rxs_pkg::RXS_LF_FAULT: begin
        if (process_lfi && lf_word_seen) begin
          next_good_cnt = '0;
        end else if (good_cnt == rxs_pkg::LF_CLEAR) begin
          next_lf_state = rxs_pkg::RXS_LF_OK;
        end else begin
          next_good_cnt = good_cnt + 7'h01;
        end
      end
      default: begin
        next_lf_state = rxs_pkg::RXS_LF_OK;
      end
    endcase
    next_received_lf = (next_lf_state == rxs_pkg::RXS_LF_FAULT);
    next_high_ber = ber_over;
    next_internal_lf = test_pattern_gen | next_aligned_err | ber_over;
  end

  // combined fault from the two registered sources
  assign local_fault = internal_local_fault | received_local_fault;

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  // status flops clear in reset; mf_cnt loads MF_LEN_RST and lf_state RXS_LF_OK
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      seen_ok <= '0;
      armed <= 1'b0;
      err_pending <= 1'b0;
      mf_cnt <= rxs_pkg::MF_LEN_RST;
      misaligned_pulse <= 1'b0;
      aligned_err <= 1'b0;
      remote_fault <= 1'b0;
      phys_lane_pcs_index <= '0;
      pcs_lane_demux_done <= '0;
      bip_err_pulse <= '0;
      marker_word_err_pulse <= '0;
      bad_fcs_count <= '0;
      stomped_fcs_count <= '0;
      truncated_pulse <= 1'b0;
      byte_cnt <= rxs_pkg::LEN_RST;
      in_trunc <= 1'b0;
      preamble_out <= '0;
      lf_state <= rxs_pkg::RXS_LF_OK;
      lf_cnt <= '0;
      good_cnt <= '0;
      received_local_fault <= 1'b0;
      internal_local_fault <= 1'b0;
      high_error_rate_level <= 1'b0;
    end else begin
      seen_ok <= next_seen_ok;
      armed <= next_armed;
      err_pending <= next_err_pending;
      mf_cnt <= next_mf_cnt;
      misaligned_pulse <= next_misaligned_pulse;
      aligned_err <= next_aligned_err;
      remote_fault <= next_remote_fault;
      phys_lane_pcs_index <= next_index;
      pcs_lane_demux_done <= next_demux;
      bip_err_pulse <= next_bip;
      marker_word_err_pulse <= next_mfe;
      bad_fcs_count <= next_bad;
      stomped_fcs_count <= next_stomp;
      truncated_pulse <= next_truncated;
      byte_cnt <= next_byte_cnt;
      in_trunc <= next_in_trunc;
      preamble_out <= next_preamble;
      lf_state <= next_lf_state;
      lf_cnt <= next_lf_cnt;
      good_cnt <= next_good_cnt;
      received_local_fault <= next_received_lf;
      internal_local_fault <= next_internal_lf;
      high_error_rate_level <= next_high_ber;
    end
  end

endmodule

// ### test/rxs_partner.sv
// Purpose: link partner model giving lane marker and fault word events
// Assumes: mode changes just after the falling edge
// Notes: mode 0 quiet, 1 good markers, 2 wrong marker on lane 0, 3 fault words
`timescale 1ns/100ps
module rxs_partner (
  input wire logic rst_b, // reset, active low
  input wire logic [1:0] mode, // event kind
  output logic [rxs_pkg::PCS_LANE_COUNT-1:0] marker_ok, // good markers
  output logic [rxs_pkg::PCS_LANE_COUNT-1:0] marker_bad, // wrong markers
  output logic [rxs_pkg::PCS_LANE_COUNT-1:0] synced, // word sync
  output logic [rxs_pkg::PCS_LANE_COUNT*rxs_pkg::LANE_IDX_W-1:0] lane_id, // pcs lane ids
  output logic lf_word // local fault word
);
  // lanes lose sync in reset; lane i carries pcs lane (i plus 7) modulo 20
  always_comb begin
    synced = rst_b ? '1 : '0;
    marker_ok = (rst_b && mode == 2'h1) ? '1 : '0;
    marker_bad = (rst_b && mode == 2'h2) ? 20'h0_0001 : '0;
    lf_word = rst_b && mode == 2'h3;
    for (int i = 0; i < rxs_pkg::PCS_LANE_COUNT; i++) lane_id[i*5 +: 5] = 5'((i + 7) % 20);
  end
endmodule

// ### test/rxs_status_assertions.sv
// Purpose: port level checks of the receive status block
// Assumes: one clock, async active low reset
// Notes: attached by the bind after the module
`timescale 1ns/100ps
module rxs_status_assertions (
  input wire logic clock, // clock
  input wire logic rst_b, // reset, active low
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] lane_marker_ok, // good markers
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] lane_synced, // word sync
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] lane_bip_bad, // bip errors in
  input wire logic align_fail, // aligner failure
  input wire logic remote_fault_seen, // remote fault in
  input wire logic ber_over, // ber over threshold
  input wire rxs_pkg::rxs_pkt_t pkt, // packet beat
  input wire logic pkt_valid, // beat valid
  input wire logic custom_preamble_enable, // preamble enable
  input wire logic [rxs_pkg::PRE_W-1:0] preamble_in, // preamble in
  input wire logic aligned_err, // alignment error
  input wire logic misaligned_pulse, // misalign pulse
  input wire logic remote_fault, // remote fault
  input wire logic [rxs_pkg::CNT_W-1:0] bad_fcs_count, // bad fcs pulse
  input wire logic [rxs_pkg::CNT_W-1:0] stomped_fcs_count, // stomped pulse
  input wire logic truncated_pulse, // truncation pulse
  input wire logic truncate_now, // truncation now
  input wire logic internal_local_fault, // internal fault
  input wire logic received_local_fault, // received fault
  input wire logic local_fault, // combined fault
  input wire logic [rxs_pkg::PCS_LANE_COUNT-1:0] bip_err_pulse, // bip pulses
  input wire logic high_error_rate_level, // high ber
  input wire logic [rxs_pkg::PRE_W-1:0] preamble_out // preamble out
);
  // ----------------------------------------
  // helper state and checks
  // ----------------------------------------
  logic live; // high from the first edge after reset, guards past values
  logic [rxs_pkg::PCS_LANE_COUNT-1:0] seen; // lanes that showed a good marker while synced
  // helper registers, cleared by reset
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      live <= 1'b0;
      seen <= '0;
    end else begin
      live <= 1'b1;
      seen <= seen | (lane_marker_ok & lane_synced);
    end
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  AST_ALIGN_FAIL: assert property (align_fail |=> aligned_err) else $error("alignment error missed");
  AST_MISALIGN_ARMED: assert property (misaligned_pulse |-> &seen) else $error("misalign before arming");
  AST_REMOTE: assert property (live |-> remote_fault == $past(remote_fault_seen)) else $error("remote fault wrong");
  AST_BAD_FCS: assert property (pkt_valid && pkt.eop && !pkt.fcs_ok && !pkt.fcs_inverted |=>
    bad_fcs_count == 2'h1) else $error("bad fcs count missed");
  AST_STOMPED: assert property (pkt_valid && pkt.eop && pkt.fcs_inverted |=>
    stomped_fcs_count == 2'h1 && bad_fcs_count == 2'h0) else $error("stomped count wrong");
  AST_TRUNC: assert property (live && truncated_pulse |-> $past(truncate_now)) else $error("stray truncation");
  AST_INTERNAL_LF: assert property (ber_over |=> internal_local_fault) else $error("internal fault missed");
  AST_BIP: assert property (live |-> bip_err_pulse == $past(lane_bip_bad)) else $error("bip pulse wrong");
  AST_HI_BER: assert property (live |-> high_error_rate_level == $past(ber_over)) else $error("high ber wrong");
  AST_PREAMBLE: assert property (pkt_valid && pkt.sop && custom_preamble_enable |=>
    preamble_out == $past(preamble_in)) else $error("preamble wrong");
  AST_LOCAL_FAULT: assert property (local_fault == (internal_local_fault || received_local_fault))
    else $error("local fault not combined");
  cover property (misaligned_pulse);
  cover property (truncated_pulse);
  cover property (stomped_fcs_count != 2'h0);
  cover property (received_local_fault);
endmodule
bind rxs_status rxs_status_assertions rxs_status_assertions_i (.*);

// ### test/rxs_status_bench.sv
// Purpose: self checking bench of the receive status block
// Assumes: inputs driven at the falling edge
// Notes: pulses are summed each cycle and compared as totals
`timescale 1ns/100ps
module rxs_status_bench;
  // ----------------------------------------
  // signals, instances and helpers
  // ----------------------------------------
  logic clock = 1'b0, rst_b = 1'b0; // clock and reset
  logic [19:0] lane_marker_ok, lane_marker_bad, lane_marker_malformed, lane_bip_bad, lane_synced;
  logic [19:0] pcs_lane_demux_done, bip_err_pulse, marker_word_err_pulse;
  logic [99:0] lane_id_in, phys_lane_pcs_index, exp_id; // lane ids and expectation
  logic align_fail, remote_fault_seen, lf_word_seen, process_lfi, test_pattern_gen, ber_over;
  logic pkt_valid, custom_preamble_enable, aligned_err, misaligned_pulse, remote_fault;
  logic truncated_pulse, truncate_now, internal_local_fault, received_local_fault, local_fault;
  logic high_error_rate_level;
  logic [1:0] bad_fcs_count, stomped_fcs_count, mode, kind; // counts, partner mode, fcs kind
  logic [14:0] max_packet_len; // length limit
  logic [55:0] preamble_in, preamble_out; // preamble buses
  logic [43:0] prev; // inputs of the last cycle
  logic [31:0] seed, r; // random state
  rxs_pkg::rxs_pkt_t pkt; // packet beat
  int failures = 0, check_count = 0, cycles = 0, beats, sum; // bookkeeping
  int tot[5] = '{default: 0}, exp_t[4] = '{default: 0}; // seen and expected totals
  always #20 clock = ~clock;
  rxs_status rxs_status_i (.*);
  rxs_partner rxs_partner_i (.rst_b(rst_b), .mode(mode), .marker_ok(lane_marker_ok), .marker_bad(lane_marker_bad),
    .synced(lane_synced), .lane_id(lane_id_in), .lf_word(lf_word_seen));
  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  // expected internal fault from align fail, ber and test pattern bits; remote fault bit ignored
  function automatic logic exp_internal(logic [3:0] f);
    return f[3] | f[1] | f[0];
  endfunction
  task automatic cyc(int n);
    repeat (n) @(negedge clock);
  endtask
  task automatic check_vec(string name, logic [127:0] expv, logic [127:0] seen);
    check_count++;
    if (seen !== expv) begin
      failures++;
      $display("unexpected %s expected %0h seen %0h", name, expv, seen);
    end
  endtask
  task final_report;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // sum pulse outputs every cycle and cut a hang short
  always @(posedge clock) begin
    cycles++;
    tot[0] += bad_fcs_count;
    tot[1] += stomped_fcs_count;
    tot[2] += truncated_pulse;
    tot[3] += misaligned_pulse;
    tot[4] += truncate_now; // same cycle cut, counted like the pulse
    if (cycles == 40000) begin
      failures++;
      final_report();
    end
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {align_fail, remote_fault_seen, process_lfi, test_pattern_gen, ber_over, pkt_valid} = '0;
    {lane_bip_bad, lane_marker_malformed, custom_preamble_enable, preamble_in} = '0;
    pkt = '0;
    max_packet_len = 15'h7fff;
    mode = 2'h0;
    seed = 32'h1146_4dd8;
    cyc(1);
    check_vec("reset outputs", 0, {aligned_err, misaligned_pulse, remote_fault,
      pcs_lane_demux_done, bad_fcs_count, stomped_fcs_count, truncated_pulse, internal_local_fault,
      received_local_fault, bip_err_pulse, marker_word_err_pulse, high_error_rate_level, local_fault,
      truncate_now});
    cyc(1);
    rst_b = 1'b1;
    // a wrong marker before any good one must stay silent
    mode = 2'h2;
    cyc(1);
    mode = 2'h0;
    cyc(16400);
    check_vec("early misalign", 0, tot[3]);
    mode = 2'h1;
    cyc(2);
    mode = 2'h0;
    cyc(1);
    for (int i = 0; i < 20; i++) exp_id[i*5 +: 5] = 5'((i + 7) % 20);
    check_vec("demux done", 20'h F_FFFF, pcs_lane_demux_done);
    check_vec("lane index", exp_id, phys_lane_pcs_index);
    // armed now: one wrong marker gives one pulse a metaframe on
    mode = 2'h2;
    cyc(1);
    mode = 2'h0;
    for (int n = 0; n < 16400 && misaligned_pulse !== 1'b1; n++) cyc(1);
    cyc(2);
    check_vec("misalign pulses", 1, tot[3]);
    // random lane events and fault levels, back to back
    repeat (300) begin
      r = rnd();
      lane_bip_bad = 20'(rnd());
      lane_marker_malformed = 20'(rnd());
      {align_fail, remote_fault_seen, ber_over, test_pattern_gen} = r[3:0] & r[7:4];
      prev = {lane_bip_bad, lane_marker_malformed, align_fail, remote_fault_seen, ber_over, test_pattern_gen};
      cyc(1);
      check_vec("bip pulse", prev[43:24], bip_err_pulse);
      check_vec("marker word pulse", prev[23:4], marker_word_err_pulse);
      check_vec("alignment error", prev[3], aligned_err);
      check_vec("remote fault", prev[2], remote_fault);
      check_vec("high ber", prev[1], high_error_rate_level);
      check_vec("internal fault", exp_internal(prev[3:0]), internal_local_fault);
    end
    {align_fail, remote_fault_seen, ber_over, test_pattern_gen, lane_bip_bad, lane_marker_malformed} = '0;
    // back to back packets of random size, fcs kind and limit
    custom_preamble_enable = 1'b1;
    pkt_valid = 1'b1;
    repeat (40) begin
      r = rnd();
      kind = 2'(r[1:0] % 3);
      beats = r[3:2] + 1;
      sum = 0;
      max_packet_len = (kind == 2'h0) ? 15'(r[9:4]) : 15'h7fff;
      for (int b = 0; b < beats; b++) begin
        pkt = '{sop: b == 0, eop: b == beats - 1, fcs_ok: kind == 2'h0, fcs_inverted: kind == 2'h2,
          bytes: 8'(1 + rnd() % 16)};
        sum += pkt.bytes;
        preamble_in = 56'({rnd(), rnd()});
        cyc(1);
        if (b == 0) check_vec("preamble", preamble_in, preamble_out);
      end
      exp_t[0] += (kind == 2'h1);
      exp_t[1] += (kind == 2'h2);
      exp_t[2] += (sum > max_packet_len);
    end
    pkt_valid = 1'b0;
    cyc(3);
    check_vec("bad fcs total", exp_t[0], tot[0]);
    check_vec("stomped total", exp_t[1], tot[1]);
    check_vec("truncation total", exp_t[2], tot[2]);
    check_vec("truncate now total", exp_t[2], tot[4]);
    // fault words: ignored when disabled, then entered, then left
    mode = 2'h3;
    cyc(6);
    check_vec("ignored fault words", 0, received_local_fault);
    process_lfi = 1'b1;
    cyc(6);
    check_vec("received fault", 1, received_local_fault);
    check_vec("local fault", 1, local_fault);
    mode = 2'h0;
    cyc(135);
    check_vec("fault cleared", 0, {received_local_fault, local_fault});
    final_report();
  end
endmodule
